// ---- src/aclf_cfg.svh ----
// Register offsets, field positions, reset values and limit windows of the channel limit block
`ifndef ACLF_CFG_SVH
`define ACLF_CFG_SVH
// Register word addresses (one register per address, 16-bit data in low bits)
`define ACLF_ADDR_W         5
`define ACLF_REG_UNIT_CTRL  5'h00
`define ACLF_REG_CH_SEL     5'h01
`define ACLF_REG_CH_CTRL    5'h02
`define ACLF_REG_USR_UPPER  5'h03
`define ACLF_REG_USR_LOWER  5'h04
`define ACLF_REG_SCL_UPPER  5'h05
`define ACLF_REG_SCL_LOWER  5'h06
`define ACLF_REG_FAULT_VAL  5'h07
`define ACLF_REG_IDLE_VAL   5'h08
`define ACLF_REG_STATUS     5'h09
`define ACLF_REG_OUT_VAL    5'h0A
`define ACLF_REG_REJECT     5'h0B
// Unit control fields
`define ACLF_UC_OVER_EN     0
`define ACLF_UC_UNDER_EN    1
`define ACLF_UC_FMT_LSB     2
`define ACLF_UC_SW_PRIO     4
// Channel control fields
`define ACLF_CC_RANGE_LSB   0
`define ACLF_CC_USR_UP_EN   3
`define ACLF_CC_USR_LO_EN   4
`define ACLF_CC_SCL_UP_EN   5
`define ACLF_CC_SCL_LO_EN   6
`define ACLF_CC_FAULT_EN    7
`define ACLF_CC_IDLE_EN     8
// Status fields
`define ACLF_ST_OVER        0
`define ACLF_ST_UNDER       1
`define ACLF_ST_USR_UP      2
`define ACLF_ST_USR_LO      3
`define ACLF_ST_SCL_UP      4
`define ACLF_ST_SCL_LO      5
// Reset values
`define ACLF_RST_RANGE      3'h2
`define ACLF_RST_SCL_UPPER  16'sh03E8
`define ACLF_RST_SCL_LOWER  16'sh0000
`define ACLF_RST_ZERO       16'h0000
// Scaled-format setting windows
`define ACLF_SCL_UP_MIN     -32'sd32766
`define ACLF_SCL_UP_MAX     32'sd32767
`define ACLF_SCL_LO_MIN     -32'sd32767
`define ACLF_SCL_LO_MAX     32'sd32766
// Non-scaled windows, value is volts or milliamps times 100
`define ACLF_V10_MIN        17'sd0
`define ACLF_V10_MAX        17'sd1050
`define ACLF_V10_LO_MAX     17'sd1045
`define ACLF_V10_UP_MIN     17'sd5
`define ACLF_V5_MIN         17'sd0
`define ACLF_V5_MAX         17'sd525
`define ACLF_V5_LO_MAX      17'sd522
`define ACLF_V5_UP_MIN      17'sd3
`define ACLF_V15_MIN        17'sd75
`define ACLF_V15_MAX        17'sd525
`define ACLF_V15_LO_MAX     17'sd522
`define ACLF_V15_UP_MIN     17'sd78
`define ACLF_I20_MIN        17'sd0
`define ACLF_I20_MAX        17'sd2100
`define ACLF_I20_LO_MAX     17'sd2090
`define ACLF_I20_UP_MIN     17'sd10
`define ACLF_I420_MIN       17'sd300
`define ACLF_I420_MAX       17'sd2100
`define ACLF_I420_LO_MAX    17'sd2090
`define ACLF_I420_UP_MIN    17'sd310
// Nominal span ends, used for the 0.5 % over and under range margin
`define ACLF_V10_NOM_HI     17'sd1000
`define ACLF_V5_NOM_HI      17'sd500
`define ACLF_V15_NOM_LO     17'sd100
`define ACLF_V15_NOM_HI     17'sd500
`define ACLF_I20_NOM_HI     17'sd2000
`define ACLF_I420_NOM_LO    17'sd400
`define ACLF_I420_NOM_HI    17'sd2000
`define ACLF_MARGIN_DIV     200
`endif

// ---- src/aclf_pkg.sv ----
// Types shared by the channel limit block
package aclf_pkg;
	typedef enum logic [2:0] {
		ACLF_RNG_0_10V  = 3'h0,
		ACLF_RNG_0_5V   = 3'h1,
		ACLF_RNG_1_5V   = 3'h2,
		ACLF_RNG_0_20MA = 3'h3,
		ACLF_RNG_4_20MA = 3'h4
	} aclf_range_type;
	typedef enum logic [1:0] {
		ACLF_FMT_OFFSET = 2'h0,
		ACLF_FMT_SIGNED = 2'h1,
		ACLF_FMT_TWOS   = 2'h2,
		ACLF_FMT_SCALED = 2'h3
	} aclf_fmt_type;
	typedef enum logic [1:0] {
		ACLF_LNK_RUN   = 2'h0,
		ACLF_LNK_FAULT = 2'h1,
		ACLF_LNK_IDLE  = 2'h2
	} aclf_link_type;
	typedef enum logic [2:0] {
		ACLF_K_VALUE = 3'h0,
		ACLF_K_USR_LO = 3'h1,
		ACLF_K_USR_UP = 3'h2,
		ACLF_K_SCL_LO = 3'h3,
		ACLF_K_SCL_UP = 3'h4
	} aclf_kind_type;
endpackage

// ---- src/aclf_win_if.sv ----
// Carries a value to the window checker and its verdict back
`timescale 1ns/100ps
interface aclf_win_if;
	import aclf_pkg::*;
	logic [15:0]    raw;
	aclf_kind_type  kind;
	aclf_range_type range;
	aclf_fmt_type   fmt;
	logic           ok;
	logic signed [16:0] val;
	modport chk (input raw, input kind, input range, input fmt, output ok, output val);
	modport use_side (output raw, output kind, output range, output fmt, input ok, input val);
endinterface

// ---- src/aclf_win_chk.sv ----
// Decodes a set value into a signed number and checks it against its window
`timescale 1ns/100ps
`include "aclf_cfg.svh"
module aclf_win_chk (
	aclf_win_if.chk w
);
	import aclf_pkg::*;
	logic signed [16:0] dec;
	logic signed [16:0] lo_b;
	logic signed [16:0] hi_b;
	logic               scaled;
	assign scaled = (w.fmt == ACLF_FMT_SCALED);
	// Scaled values use bit 15 as sign, magnitude below
	assign dec = (scaled && w.raw[15]) ? -$signed({2'b00, w.raw[14:0]})
	           : $signed({1'b0, w.raw});
	assign w.val = dec;
	always_comb begin
		lo_b = `ACLF_V10_MIN;
		hi_b = `ACLF_V10_MAX;
		if (scaled) begin
			lo_b = -17'sd32767;
			hi_b = 17'sd32767;
			if (w.kind == ACLF_K_SCL_UP) lo_b = 17'(`ACLF_SCL_UP_MIN);
			if (w.kind == ACLF_K_SCL_LO) hi_b = 17'(`ACLF_SCL_LO_MAX);
		end else begin
			case (w.range)
				ACLF_RNG_0_10V: begin
					lo_b = (w.kind == ACLF_K_USR_UP) ? `ACLF_V10_UP_MIN : `ACLF_V10_MIN;
					hi_b = (w.kind == ACLF_K_USR_LO) ? `ACLF_V10_LO_MAX : `ACLF_V10_MAX;
				end
				ACLF_RNG_0_5V: begin
					lo_b = (w.kind == ACLF_K_USR_UP) ? `ACLF_V5_UP_MIN : `ACLF_V5_MIN;
					hi_b = (w.kind == ACLF_K_USR_LO) ? `ACLF_V5_LO_MAX : `ACLF_V5_MAX;
				end
				ACLF_RNG_1_5V: begin
					lo_b = (w.kind == ACLF_K_USR_UP) ? `ACLF_V15_UP_MIN : `ACLF_V15_MIN;
					hi_b = (w.kind == ACLF_K_USR_LO) ? `ACLF_V15_LO_MAX : `ACLF_V15_MAX;
				end
				ACLF_RNG_0_20MA: begin
					lo_b = (w.kind == ACLF_K_USR_UP) ? `ACLF_I20_UP_MIN : `ACLF_I20_MIN;
					hi_b = (w.kind == ACLF_K_USR_LO) ? `ACLF_I20_LO_MAX : `ACLF_I20_MAX;
				end
				ACLF_RNG_4_20MA: begin
					lo_b = (w.kind == ACLF_K_USR_UP) ? `ACLF_I420_UP_MIN : `ACLF_I420_MIN;
					hi_b = (w.kind == ACLF_K_USR_LO) ? `ACLF_I420_LO_MAX : `ACLF_I420_MAX;
				end
				default: begin
					lo_b = 17'sd1;
					hi_b = 17'sd0;
				end
			endcase
		end
	end
	// Scaled-format sign-magnitude "-0" decodes to 0 and is accepted
	assign w.ok = (dec >= lo_b) && (dec <= hi_b);
endmodule

// ---- src/aclf_top.sv ----
// Per-channel limit checking and fault/idle output substitution for an analogue unit
//
// What this block does and what it expects of the controller
// (R1) Enabled over-range: error above range plus 0.5%
// (R2) Enabled under-range: error below range minus 0.5%
// (R3) User upper check flags value above limit
// (R4) User lower check flags value below limit
// (R5) Scale upper: -32766..32767, default 1000, checked
// (R6) Scale lower: -32767..32766, default 0, checked
// (R7) Comm fault: fault value or hold last
// (R8) Comm idle: idle value or hold last
// (R9) Substitution only under software hold/clear priority
// (R10) Controller encodes non-scaled values as units x100
// (R11) Non-scaled set values limited per range table
// (R12) Scaled values are 16-bit sign-magnitude
// (R13) User limits confined to range-specific windows; in scaled format the write check uses the full -32767..32767 window instead
// (R14) Controller re-checks values after range change
// (R15) Out-of-window writes rejected, old value kept
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "aclf_cfg.svh"
module aclf_top (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire logic                      clk_en,
	input  wire logic [`ACLF_ADDR_W-1:0]   reg_addr,
	input  wire logic [15:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [15:0]               reg_rdata,
	input  wire logic                      comm_fault,
	input  wire logic                      comm_idle,
	input  wire logic [1:0]                in_ch,
	input  wire logic [15:0]               in_value,
	input  wire logic                      in_valid,
	input  wire logic [1:0]                out_ch,
	input  wire logic [15:0]               out_value,
	input  wire logic                      out_valid,
	output logic      [15:0]               drive_value [4],
	output logic      [3:0]                ch_error,
	output logic                           over_range_err,
	output logic                           under_range_err
);
	import aclf_pkg::*;
	localparam int NCH = 4;

	// Unit-wide settings
	logic           over_en_r;
	logic           under_en_r;
	aclf_fmt_type   fmt_r;
	logic           sw_prio_r;
	logic [1:0]     sel_r;
	// Per-channel settings
	aclf_range_type range_r   [NCH];
	logic [5:0]     ccen_r    [NCH];
	logic [15:0]    usr_up_r  [NCH];
	logic [15:0]    usr_lo_r  [NCH];
	logic [15:0]    scl_up_r  [NCH];
	logic [15:0]    scl_lo_r  [NCH];
	logic [15:0]    fault_r   [NCH];
	logic [15:0]    idle_r    [NCH];
	logic [15:0]    last_r    [NCH];
	logic [5:0]     stat_r    [NCH];
	logic           reject_r;
	logic [15:0]    rdata_r;
	logic [15:0]    rd_mux;
	// Pin synchronisers for the link state lines
	logic [2:0]     flt_sy_r;
	logic [2:0]     idl_sy_r;
	logic           flt_r;
	logic           idl_r;
	aclf_link_type  link_r;
	aclf_link_type  link_nxt;

	// Window check for register writes
	aclf_win_if wr_w ();
	aclf_win_chk u_wr_chk (.w(wr_w));
	// Decoder for the value under comparison
	aclf_win_if sm_w ();
	aclf_win_chk u_sm_chk (.w(sm_w));

	wire        sel_wr_ctl = reg_wr && (reg_addr == `ACLF_REG_CH_CTRL);
	wire        wr_usr_up  = reg_wr && (reg_addr == `ACLF_REG_USR_UPPER);
	wire        wr_usr_lo  = reg_wr && (reg_addr == `ACLF_REG_USR_LOWER);
	wire        wr_scl_up  = reg_wr && (reg_addr == `ACLF_REG_SCL_UPPER);
	wire        wr_scl_lo  = reg_wr && (reg_addr == `ACLF_REG_SCL_LOWER);
	wire        wr_fault   = reg_wr && (reg_addr == `ACLF_REG_FAULT_VAL);
	wire        wr_idle    = reg_wr && (reg_addr == `ACLF_REG_IDLE_VAL);
	wire        wr_value   = wr_usr_up | wr_usr_lo | wr_scl_up | wr_scl_lo | wr_fault | wr_idle;
	wire        wr_accept  = wr_value && wr_w.ok; // R15
	wire        rd_status  = reg_rd && (reg_addr == `ACLF_REG_STATUS);

	assign wr_w.raw   = reg_wdata;
	assign wr_w.range = range_r[sel_r];
	assign wr_w.fmt   = fmt_r;
	assign wr_w.kind  = wr_usr_up ? ACLF_K_USR_UP :
	                    wr_usr_lo ? ACLF_K_USR_LO : // R13
	                    wr_scl_up ? ACLF_K_SCL_UP : // R5
	                    wr_scl_lo ? ACLF_K_SCL_LO : ACLF_K_VALUE; // R6 R11 R12

	// One sample per cycle is checked; input samples have priority over output samples
	wire        smp_v   = in_valid | out_valid;
	wire        smp_in  = in_valid;
	wire [1:0]  smp_ch  = in_valid ? in_ch : out_ch;
	assign sm_w.raw   = in_valid ? in_value : out_value;
	assign sm_w.range = range_r[smp_ch];
	assign sm_w.fmt   = fmt_r;
	assign sm_w.kind  = ACLF_K_VALUE;
	wire signed [16:0] smp = sm_w.val;

	function automatic logic signed [16:0] dec16(input logic [15:0] r, input logic sc);
		logic signed [16:0] d;
		d = (sc && r[15]) ? -$signed({2'b00, r[14:0]}) : $signed({1'b0, r});
		return d;
	endfunction
	wire sc = (fmt_r == ACLF_FMT_SCALED);
	wire signed [16:0] u_up = dec16(usr_up_r[smp_ch], sc);
	wire signed [16:0] u_lo = dec16(usr_lo_r[smp_ch], sc);
	wire signed [16:0] s_up = dec16(scl_up_r[smp_ch], 1'b1);
	wire signed [16:0] s_lo = dec16(scl_lo_r[smp_ch], 1'b1);

	// Nominal span of the sample's range; scaled span comes from the scale limits
	logic signed [16:0] nom_lo;
	logic signed [16:0] nom_hi;
	always_comb begin
		nom_lo = 17'sd0;
		nom_hi = `ACLF_V10_NOM_HI;
		case (range_r[smp_ch])
			ACLF_RNG_0_10V:  nom_hi = `ACLF_V10_NOM_HI;
			ACLF_RNG_0_5V:   nom_hi = `ACLF_V5_NOM_HI;
			ACLF_RNG_1_5V: begin
				nom_lo = `ACLF_V15_NOM_LO;
				nom_hi = `ACLF_V15_NOM_HI;
			end
			ACLF_RNG_0_20MA: nom_hi = `ACLF_I20_NOM_HI;
			ACLF_RNG_4_20MA: begin
				nom_lo = `ACLF_I420_NOM_LO;
				nom_hi = `ACLF_I420_NOM_HI;
			end
			default: nom_hi = `ACLF_V10_NOM_HI;
		endcase
		if (sc) begin
			nom_lo = s_lo;
			nom_hi = s_up;
		end
	end
	// Span margin truncates, so the trip point is never looser than 0.5 %
	wire signed [18:0] span   = 19'(nom_hi) - 19'(nom_lo);
	wire signed [18:0] margin = 19'(span / `ACLF_MARGIN_DIV);
	wire hit_over  = smp_in && (19'(smp) > 19'(nom_hi) + margin); // R1
	wire hit_under = smp_in && (19'(smp) < 19'(nom_lo) - margin); // R2
	wire hit_uup   = ccen_r[smp_ch][0] && (smp > u_up); // R3
	wire hit_ulo   = ccen_r[smp_ch][1] && (smp < u_lo); // R4
	wire hit_sup   = ccen_r[smp_ch][2] && sc && (smp > s_up); // R5
	wire hit_slo   = ccen_r[smp_ch][3] && sc && (smp < s_lo); // R6
	wire [5:0] hits = {hit_slo, hit_sup, hit_ulo, hit_uup,
	                   hit_under && under_en_r, hit_over && over_en_r};

	// Link state: fault outranks idle
	always_comb begin
		case ({flt_r, idl_r})
			2'b10, 2'b11: link_nxt = ACLF_LNK_FAULT;
			2'b01:        link_nxt = ACLF_LNK_IDLE;
			default:      link_nxt = ACLF_LNK_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flt_sy_r <= 3'h0;
			idl_sy_r <= 3'h0;
			flt_r    <= 1'b0;
			idl_r    <= 1'b0;
			link_r   <= ACLF_LNK_RUN;
		end else if (clk_en) begin
			flt_sy_r <= {flt_sy_r[1:0], comm_fault};
			idl_sy_r <= {idl_sy_r[1:0], comm_idle};
			if (flt_sy_r[1] == flt_sy_r[2]) flt_r <= flt_sy_r[2];
			if (idl_sy_r[1] == idl_sy_r[2]) idl_r <= idl_sy_r[2];
			link_r   <= link_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			over_en_r  <= 1'b0;
			under_en_r <= 1'b0;
			fmt_r      <= ACLF_FMT_OFFSET;
			sw_prio_r  <= 1'b0;
			sel_r      <= 2'h0;
			reject_r   <= 1'b0;
			rdata_r    <= `ACLF_RST_ZERO;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == `ACLF_REG_UNIT_CTRL) begin
				over_en_r  <= reg_wdata[`ACLF_UC_OVER_EN];
				under_en_r <= reg_wdata[`ACLF_UC_UNDER_EN];
				fmt_r      <= aclf_fmt_type'(reg_wdata[`ACLF_UC_FMT_LSB +: 2]);
				sw_prio_r  <= reg_wdata[`ACLF_UC_SW_PRIO];
			end
			if (reg_wr && reg_addr == `ACLF_REG_CH_SEL) sel_r <= reg_wdata[1:0];
			// Sticky: a rejected write sets it, a read of it clears it, set wins
			if (wr_value && !wr_w.ok) begin
				reject_r <= 1'b1; // R15
			end else if (reg_rd && reg_addr == `ACLF_REG_REJECT) begin
				reject_r <= 1'b0;
			end
			rdata_r <= rd_mux;
		end
	end

	always_comb begin
		case (reg_addr)
			`ACLF_REG_UNIT_CTRL: rd_mux = {11'h0, sw_prio_r, fmt_r, under_en_r, over_en_r};
			`ACLF_REG_CH_SEL:    rd_mux = {14'h0, sel_r};
			`ACLF_REG_CH_CTRL:   rd_mux = {7'h0, ccen_r[sel_r], range_r[sel_r]};
			`ACLF_REG_USR_UPPER: rd_mux = usr_up_r[sel_r];
			`ACLF_REG_USR_LOWER: rd_mux = usr_lo_r[sel_r];
			`ACLF_REG_SCL_UPPER: rd_mux = scl_up_r[sel_r];
			`ACLF_REG_SCL_LOWER: rd_mux = scl_lo_r[sel_r];
			`ACLF_REG_FAULT_VAL: rd_mux = fault_r[sel_r];
			`ACLF_REG_IDLE_VAL:  rd_mux = idle_r[sel_r];
			`ACLF_REG_STATUS:    rd_mux = {10'h0, stat_r[sel_r]};
			`ACLF_REG_OUT_VAL:   rd_mux = drive_value[sel_r];
			`ACLF_REG_REJECT:    rd_mux = {15'h0, reject_r};
			default:             rd_mux = 16'h0000;
		endcase
	end
	assign reg_rdata = rdata_r;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			wire mine  = (sel_r == 2'(g));
			wire hit_g = smp_v && (smp_ch == 2'(g));
			wire sub_ok = sw_prio_r; // R9
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					range_r[g]  <= aclf_range_type'(`ACLF_RST_RANGE);
					ccen_r[g]   <= 6'h00;
					usr_up_r[g] <= `ACLF_RST_ZERO;
					usr_lo_r[g] <= `ACLF_RST_ZERO;
					scl_up_r[g] <= `ACLF_RST_SCL_UPPER; // R5
					scl_lo_r[g] <= `ACLF_RST_SCL_LOWER; // R6
					fault_r[g]  <= `ACLF_RST_ZERO;
					idle_r[g]   <= `ACLF_RST_ZERO;
					last_r[g]   <= `ACLF_RST_ZERO;
					stat_r[g]   <= 6'h00;
				end else if (clk_en) begin
					if (mine && sel_wr_ctl) begin
						range_r[g] <= aclf_range_type'(reg_wdata[`ACLF_CC_RANGE_LSB +: 3]);
						ccen_r[g]  <= reg_wdata[`ACLF_CC_IDLE_EN:`ACLF_CC_USR_UP_EN];
					end
					if (mine && wr_accept && wr_usr_up) usr_up_r[g] <= reg_wdata;
					if (mine && wr_accept && wr_usr_lo) usr_lo_r[g] <= reg_wdata;
					if (mine && wr_accept && wr_scl_up) scl_up_r[g] <= reg_wdata;
					if (mine && wr_accept && wr_scl_lo) scl_lo_r[g] <= reg_wdata;
					if (mine && wr_accept && wr_fault)  fault_r[g]  <= reg_wdata;
					if (mine && wr_accept && wr_idle)   idle_r[g]   <= reg_wdata;
					// Last state is only tracked while the link runs, so hold keeps it
					if (out_valid && out_ch == 2'(g) && link_r == ACLF_LNK_RUN) begin
						last_r[g] <= out_value;
					end
					// Status sticky; reading it clears, a new hit in that cycle wins
					if (hit_g) begin
						stat_r[g] <= (mine && rd_status) ? hits : (stat_r[g] | hits);
					end else if (mine && rd_status) begin
						stat_r[g] <= 6'h00;
					end
				end
			end
			always_comb begin
				case (link_r)
					ACLF_LNK_FAULT: drive_value[g] = (sub_ok && ccen_r[g][4]) ?
					                                 fault_r[g] : last_r[g]; // R7
					ACLF_LNK_IDLE:  drive_value[g] = (sub_ok && ccen_r[g][5]) ?
					                                 idle_r[g] : last_r[g]; // R8
					default:        drive_value[g] = last_r[g];
				endcase
			end
			assign ch_error[g] = |stat_r[g][5:2];
		end
	endgenerate

	assign over_range_err  = stat_r[0][0] | stat_r[1][0] | stat_r[2][0] | stat_r[3][0];
	assign under_range_err = stat_r[0][1] | stat_r[1][1] | stat_r[2][1] | stat_r[3][1];
endmodule

// ---- verif/aclf_chk_sva.sv ----
// Port-level assertions for the channel limit block
`timescale 1ns/100ps
`include "aclf_cfg.svh"
module aclf_chk (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    clk_en,
	input  wire logic [`ACLF_ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [15:0]             reg_rdata,
	input  wire logic                    comm_fault,
	input  wire logic                    comm_idle,
	input  wire logic                    in_valid,
	input  wire logic [1:0]              out_ch,
	input  wire logic [15:0]             out_value,
	input  wire logic                    out_valid,
	input  wire logic [15:0]             drive_value [4],
	input  wire logic [3:0]              ch_error,
	input  wire logic                    over_range_err,
	input  wire logic                    under_range_err
);
	logic [1:0]  uc_r;
	logic [1:0]  sel_r;
	logic [1:0]  pins_r;
	logic [3:0]  quiet_r;
	logic [15:0] sel_drv;
	wire         pin_chg = {comm_fault, comm_idle} != pins_r;
	assign sel_drv = drive_value[sel_r];
	// Shadows of enables and select; quiet_r counts cycles since the link pins moved
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			uc_r    <= 2'h0;
			sel_r   <= 2'h0;
			pins_r  <= 2'h0;
			quiet_r <= 4'h0;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == `ACLF_REG_UNIT_CTRL)
				uc_r <= reg_wdata[1:0];
			if (reg_wr && reg_addr == `ACLF_REG_CH_SEL)
				sel_r <= reg_wdata[1:0];
			pins_r  <= {comm_fault, comm_idle};
			quiet_r <= pin_chg ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence rd_quiet(a);
		reg_rd && clk_en && reg_addr == a && !in_valid && !out_valid
			&& !$past(in_valid) && !$past(out_valid);
	endsequence
	over_cause_a: assert property ($rose(over_range_err) |-> uc_r[0] &&
		($past(in_valid) || $past(in_valid, 2))) else $error("over range without enabled sample");
	under_cause_a: assert property ($rose(under_range_err) |-> uc_r[1] &&
		($past(in_valid) || $past(in_valid, 2))) else $error("under range without enabled sample");
	limit_cause_a: assert property ($rose(|ch_error) |->
		$past(in_valid || out_valid) || $past(in_valid || out_valid, 2))
		else $error("channel error without a sample");
	status_clear_a: assert property (rd_quiet(`ACLF_REG_STATUS) ##1
		rd_quiet(`ACLF_REG_STATUS) |=> reg_rdata[5:0] == 6'h00) else $error("status not cleared");
	reject_clear_a: assert property (rd_quiet(`ACLF_REG_REJECT) ##1
		rd_quiet(`ACLF_REG_REJECT) |=> reg_rdata[0] == 1'b0) else $error("reject not cleared");
	drive_hold_a: assert property (quiet_r == 4'hF && !$past(reg_wr) && !$past(out_valid)
		|-> $stable(drive_value[0])) else $error("drive value moved with no cause");
	drive_follow_a: assert property (quiet_r == 4'hF && !comm_fault && !comm_idle && clk_en
		&& out_valid && !in_valid && out_ch == 2'h0 |=> drive_value[0] == $past(out_value))
		else $error("drive value did not follow output write");
	drive_read_a: assert property (reg_rd && clk_en && reg_addr == `ACLF_REG_OUT_VAL
		|=> reg_rdata == $past(sel_drv)) else $error("drive value readback wrong");
endmodule
bind aclf_top aclf_chk aclf_chk_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .comm_fault(comm_fault), .comm_idle(comm_idle),
	.in_valid(in_valid), .out_ch(out_ch), .out_value(out_value), .out_valid(out_valid),
	.drive_value(drive_value), .ch_error(ch_error), .over_range_err(over_range_err),
	.under_range_err(under_range_err));

// ---- verif/aclf_plc_model.sv ----
// Fieldbus controller model: link state pins and output value writes
`timescale 1ns/100ps
module aclf_plc_model (
	input  wire logic        clk,
	input  wire logic [1:0]  link,
	output logic             comm_fault,
	output logic             comm_idle,
	output logic [1:0]       out_ch,
	output logic [15:0]      out_value,
	output logic             out_valid
);
	import aclf_pkg::*;
	initial begin
		comm_fault = 1'b0;
		comm_idle  = 1'b0;
		out_ch     = 2'h0;
		out_value  = 16'h5A5A;
		out_valid  = 1'b0;
	end
	// Code 3 raises both pins at once
	always @(posedge clk) begin
		comm_fault <= link == ACLF_LNK_FAULT || link == 2'h3;
		comm_idle  <= link == ACLF_LNK_IDLE || link == 2'h3;
	end
	task automatic send(input logic [1:0] ch, input logic [15:0] v);
		@(posedge clk);
		out_ch    <= ch;
		out_value <= v;
		out_valid <= 1'b1;
		@(posedge clk);
		out_valid <= 1'b0;
		// Released data does not keep its last value
		out_value <= ~v;
		@(posedge clk);
	endtask
endmodule

// ---- verif/aclf_top_test.sv ----
// Self-checking bench for the channel limit block
`timescale 1ns/100ps
`include "aclf_cfg.svh"
module aclf_top_test;
	import aclf_pkg::*;
	logic                    clk       = 1'b0;
	logic                    sys_rst   = 1'b1;
	logic                    clk_en    = 1'b1;
	logic [`ACLF_ADDR_W-1:0] reg_addr  = 5'h00;
	logic [15:0]             reg_wdata = 16'h0000;
	logic                    reg_wr    = 1'b0;
	logic                    reg_rd    = 1'b0;
	logic [1:0]              in_ch     = 2'h0;
	logic [15:0]             in_value  = 16'h0000;
	logic                    in_valid  = 1'b0;
	logic [1:0]              link      = ACLF_LNK_RUN;
	logic [15:0]             reg_rdata;
	logic                    comm_fault;
	logic                    comm_idle;
	logic [1:0]              out_ch;
	logic [15:0]             out_value;
	logic                    out_valid;
	logic [15:0]             drive_value [4];
	logic [3:0]              ch_error;
	logic                    over_range_err;
	logic                    under_range_err;
	logic [15:0]             rv;
	int                      errors    = 0;
	int                      n_tests   = 0;
	int                      cyc       = 0;
	logic [15:0] hi [5] = '{16'h041A, 16'h020D, 16'h020D, 16'h0834, 16'h0834};
	logic [15:0] lo [5] = '{16'h0000, 16'h0000, 16'h004B, 16'h0000, 16'h012C};
	logic [15:0] lmx [5] = '{16'h0415, 16'h020A, 16'h020A, 16'h082A, 16'h082A};
	logic [15:0] umn [5] = '{16'h0005, 16'h0003, 16'h004E, 16'h000A, 16'h0136};
	aclf_top aclf_top_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .comm_fault(comm_fault), .comm_idle(comm_idle),
		.in_ch(in_ch), .in_value(in_value), .in_valid(in_valid), .out_ch(out_ch),
		.out_value(out_value), .out_valid(out_valid), .drive_value(drive_value),
		.ch_error(ch_error), .over_range_err(over_range_err), .under_range_err(under_range_err));
	aclf_plc_model aclf_plc_model_inst (.clk(clk), .link(link), .comm_fault(comm_fault),
		.comm_idle(comm_idle), .out_ch(out_ch), .out_value(out_value), .out_valid(out_valid));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("errors %0d, comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(exp, reg_rdata);
	endtask
	// Write, then read the reject flag and the stored value back
	task automatic wrc(input logic [4:0] a, input logic [15:0] v, input logic ok,
		input logic [15:0] prev);
		wr(a, v);
		rc(`ACLF_REG_REJECT, {15'h0000, !ok});
		rc(a, ok ? v : prev);
	endtask
	task automatic smp(input logic [15:0] v);
		@(posedge clk);
		in_valid <= 1'b1;
		in_value <= v;
		@(posedge clk);
		in_valid <= 1'b0;
		in_value <= ~v;
		@(posedge clk);
		#1;
	endtask
	task automatic lnk(input logic [1:0] m);
		link <= m;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic rr(input logic [4:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		repeat (2) @(posedge clk);
		reg_rd <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rc(`ACLF_REG_SCL_UPPER, 16'h03E8);
		rc(`ACLF_REG_SCL_LOWER, 16'h0000);
		rc(`ACLF_REG_CH_CTRL, 16'h0002);
		rc(`ACLF_REG_UNIT_CTRL, 16'h0000);
		rc(5'h1F, 16'h0000);
		for (int r = 0; r < 5; r++) begin
			wr(`ACLF_REG_CH_CTRL, 16'(r));
			wrc(`ACLF_REG_FAULT_VAL, hi[r], 1'b1, 16'h0000);
			wrc(`ACLF_REG_FAULT_VAL, hi[r] + 16'h0001, 1'b0, hi[r]);
			if (lo[r] != 16'h0000)
				wrc(`ACLF_REG_FAULT_VAL, lo[r] - 16'h0001, 1'b0, hi[r]);
			wrc(`ACLF_REG_USR_LOWER, lmx[r], 1'b1, 16'h0000);
			wrc(`ACLF_REG_USR_LOWER, lmx[r] + 16'h0001, 1'b0, lmx[r]);
			wrc(`ACLF_REG_USR_UPPER, umn[r], 1'b1, 16'h0000);
			wrc(`ACLF_REG_USR_UPPER, umn[r] - 16'h0001, 1'b0, umn[r]);
		end
		wr(`ACLF_REG_CH_CTRL, 16'h001A);
		wrc(`ACLF_REG_USR_UPPER, 16'h0190, 1'b1, 16'h0000);
		wrc(`ACLF_REG_USR_UPPER, 16'h020E, 1'b0, 16'h0190);
		wrc(`ACLF_REG_USR_LOWER, 16'h00C8, 1'b1, 16'h0000);
		wrc(`ACLF_REG_FAULT_VAL, 16'h012C, 1'b1, 16'h0000);
		wrc(`ACLF_REG_IDLE_VAL, 16'h0096, 1'b1, 16'h0000);
		wrc(`ACLF_REG_IDLE_VAL, 16'h004A, 1'b0, 16'h0096);
		aclf_plc_model_inst.send(2'h0, 16'h0190);
		rc(`ACLF_REG_STATUS, 16'h0000);
		aclf_plc_model_inst.send(2'h0, 16'h0191);
		chk(16'h0001, {12'h000, ch_error});
		rc(`ACLF_REG_STATUS, 16'h0004);
		chk(16'h0000, {12'h000, ch_error});
		smp(16'h00C7);
		rc(`ACLF_REG_STATUS, 16'h0008);
		wr(`ACLF_REG_CH_CTRL, 16'h0002);
		wr(`ACLF_REG_UNIT_CTRL, 16'h0003);
		smp(16'h01F6);
		chk(16'h0000, {15'h0000, over_range_err});
		smp(16'h01F7);
		chk(16'h0001, {15'h0000, over_range_err});
		rc(`ACLF_REG_STATUS, 16'h0001);
		smp(16'h0062);
		chk(16'h0000, {15'h0000, under_range_err});
		smp(16'h0061);
		chk(16'h0001, {15'h0000, under_range_err});
		rc(`ACLF_REG_STATUS, 16'h0002);
		wr(`ACLF_REG_UNIT_CTRL, 16'h0000);
		smp(16'h0258);
		rc(`ACLF_REG_STATUS, 16'h0000);
		wr(`ACLF_REG_UNIT_CTRL, 16'h000C);
		wr(`ACLF_REG_CH_CTRL, 16'h0062);
		smp(16'h03E8);
		rc(`ACLF_REG_STATUS, 16'h0000);
		smp(16'h03E9);
		rc(`ACLF_REG_STATUS, 16'h0010);
		smp(16'h8000);
		rc(`ACLF_REG_STATUS, 16'h0000);
		smp(16'h8001);
		rc(`ACLF_REG_STATUS, 16'h0020);
		smp(16'h8001);
		rr(`ACLF_REG_STATUS);
		wrc(`ACLF_REG_SCL_UPPER, 16'hFFFF, 1'b0, 16'h03E8);
		wrc(`ACLF_REG_SCL_UPPER, 16'hFFFE, 1'b1, 16'h0000);
		wrc(`ACLF_REG_SCL_LOWER, 16'h7FFF, 1'b0, 16'h0000);
		wrc(`ACLF_REG_SCL_LOWER, 16'h7FFE, 1'b1, 16'h0000);
		wr(`ACLF_REG_SCL_UPPER, 16'hFFFF);
		rr(`ACLF_REG_REJECT);
		wr(`ACLF_REG_UNIT_CTRL, 16'h0000);
		wr(`ACLF_REG_CH_CTRL, 16'h0182);
		aclf_plc_model_inst.send(2'h0, 16'h00FA);
		aclf_plc_model_inst.send(2'h1, 16'h014D);
		lnk(ACLF_LNK_FAULT);
		chk(16'h00FA, drive_value[0]);
		lnk(ACLF_LNK_RUN);
		wr(`ACLF_REG_UNIT_CTRL, 16'h0010);
		lnk(ACLF_LNK_FAULT);
		chk(16'h012C, drive_value[0]);
		chk(16'h014D, drive_value[1]);
		rc(`ACLF_REG_OUT_VAL, 16'h012C);
		aclf_plc_model_inst.send(2'h0, 16'h01BC);
		lnk(ACLF_LNK_IDLE);
		chk(16'h0096, drive_value[0]);
		chk(16'h014D, drive_value[1]);
		lnk(2'h3);
		chk(16'h012C, drive_value[0]);
		lnk(ACLF_LNK_RUN);
		chk(16'h00FA, drive_value[0]);
		stop_test();
	end
endmodule
